// >>> hw/clb_defs.vh
// constants for the base-configuration link serializer
`ifndef CLB_DEFS_VH
`define CLB_DEFS_VH

// bits per lane per pixel word, and lane count
`define CLB_SLOTS        7
`define CLB_LAST_SLOT    3'h6
`define CLB_LANES        4

// link clock is 7x the pixel clock
`define CLB_LINK_MULT    7

// camera data clock divide ratios (clocks per pixel)
`define CLB_CPP_SINGLE   16
`define CLB_CPP_DUAL     7
`define CLB_CPP_BYTE     4

// pixel modes
`define CLB_MODE_8       3'h0
`define CLB_MODE_10      3'h1
`define CLB_MODE_12      3'h2
`define CLB_MODE_14      3'h3
`define CLB_MODE_16      3'h4
`define CLB_MODE_RGB     3'h5

// forwarded clock shape, first slot in bit 6
`define CLB_CLK_PATTERN  7'h63

// buffer word: {dval, fval, lval, data[23:0]}
`define CLB_WORD_W       27
`define CLB_DATA_W       24
`define CLB_W_DVAL       26
`define CLB_W_FVAL       25
`define CLB_W_LVAL       24

// reset values
`define CLB_RST_WORD     27'h000_0000
`define CLB_RST_SLOT     3'h0
`define CLB_RST_MODE     3'h3
`define CLB_RST_TAPS     2'h1

`endif

// >>> hw/clb_pixel_buffer.v
// two-entry pixel buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "clb_defs.vh"

module clb_pixel_buffer (
  // clock and reset
  input  wire                      mclk,
  input  wire                      nrst,
  // fill side
  input  wire                      inValid,
  output wire                      inReady,
  input  wire [`CLB_WORD_W-1:0]    inWord,
  // drain side
  output wire                      outValid,
  input  wire                      outReady,
  output wire [`CLB_WORD_W-1:0]    outWord
);

  reg [`CLB_WORD_W-1:0] head_q;
  reg [`CLB_WORD_W-1:0] tail_q;
  reg [1:0]             count_q;
  reg [1:0]             count_d;
  reg                   inRdy_q;
  reg                   outVld_q;
  wire                  push;
  wire                  pop;

  assign push     = inValid & inRdy_q;
  assign pop      = outVld_q & outReady;
  assign inReady  = inRdy_q;
  assign outValid = outVld_q;
  assign outWord  = head_q;

  always @* begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 2'h1;
    end else if (pop && !push) begin
      count_d = count_q - 2'h1;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      head_q   <= `CLB_RST_WORD;
      tail_q   <= `CLB_RST_WORD;
      count_q  <= 2'h0;
      inRdy_q  <= 1'b0;
      outVld_q <= 1'b0;
    end else begin
      count_q  <= count_d;
      inRdy_q  <= (count_d != 2'h2);
      outVld_q <= (count_d != 2'h0);
      if (push && !pop) begin
        if (count_q == 2'h0) begin
          head_q <= inWord;
        end else begin
          tail_q <= inWord;
        end
      end else if (pop && !push) begin
        head_q <= tail_q;
      end else if (push && pop) begin
        // one held: new word becomes head
        head_q <= inWord;
      end
    end
  end

endmodule // clb_pixel_buffer

// >>> hw/clb_lane_shifter.v
// 7:1 parallel-in serial-out shifter for one lane
`timescale 1ns/1ps
`include "clb_defs.vh"

module clb_lane_shifter (
  // clock and reset
  input  wire                    mclk,
  input  wire                    nrst,
  // parallel side
  input  wire                    load,
  input  wire [`CLB_SLOTS-1:0]   slots,
  // serial side
  output wire                    serOut
);

  reg [`CLB_SLOTS-1:0] shift_q;
  reg                  ser_q;

  assign serOut = ser_q;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= 7'h00;
      ser_q   <= 1'b0;
    end else if (load) begin
      // slot 0 sits in bit 6 and leaves first
      ser_q   <= slots[6];
      shift_q <= {slots[5:0], 1'b0};
    end else begin
      ser_q   <= shift_q[6];
      shift_q <= {shift_q[5:0], 1'b0};
    end
  end

endmodule // clb_lane_shifter

// >>> hw/clb_serializer.v
// base-configuration link transmitter: port mapping and 7:1 lanes
`timescale 1ns/1ps
`include "clb_defs.vh"

module clb_serializer (
  // clock and reset (mclk is the 7x link clock)
  input  wire                      mclk,
  input  wire                      nrst,
  // mode selection, applied at frame start
  input  wire [2:0]                pixMode,
  input  wire [1:0]                tapCount,
  // pixel stream from the capture side
  input  wire                      pixValid,
  output wire                      pixReady,
  input  wire [`CLB_DATA_W-1:0]    pixData,
  input  wire                      pixFval,
  input  wire                      pixLval,
  input  wire                      pixDval,
  // link lanes
  output wire [`CLB_LANES-1:0]     laneOut,
  output wire                      linkClkOut,
  // status
  output wire [2:0]                activeMode,
  output wire                      underrun
);

  //////////////////////////////////////////////////////////////////////////
  // buffer: every word enters, valid or not

  wire [`CLB_WORD_W-1:0] inWord;
  wire [`CLB_WORD_W-1:0] bufWord;
  wire                   bufValid;
  wire                   bufPop;

  assign inWord = {pixDval, pixFval, pixLval, pixData};

  clb_pixel_buffer uBuf (
    .mclk     (mclk),
    .nrst     (nrst),
    .inValid  (pixValid),
    .inReady  (pixReady),
    .inWord   (inWord),
    .outValid (bufValid),
    .outReady (bufPop),
    .outWord  (bufWord)
  );

  //////////////////////////////////////////////////////////////////////////
  // pixel slot counter

  reg  [2:0] slot_q;
  reg  [2:0] slot_d;
  wire       wordEdge;

  always @* begin
    if (slot_q == `CLB_LAST_SLOT) begin
      slot_d = `CLB_RST_SLOT;
    end else begin
      slot_d = slot_q + 3'h1;
    end
  end

  assign wordEdge = (slot_q == `CLB_LAST_SLOT);
  assign bufPop   = wordEdge;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slot_q <= `CLB_RST_SLOT;
    end else begin
      slot_q <= slot_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mode latch: change only on a frame-start word, avoids torn frames

  reg  [2:0] mode_q;
  reg  [1:0] taps_q;
  reg  [2:0] modeNow;
  reg  [1:0] tapsNow;
  wire       frameStart;

  assign frameStart = wordEdge & bufValid & bufWord[`CLB_W_FVAL];

  always @* begin
    modeNow = mode_q;
    tapsNow = taps_q;
    if (frameStart) begin
      modeNow = pixMode;
      tapsNow = tapCount;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= `CLB_RST_MODE;
      taps_q <= `CLB_RST_TAPS;
    end else begin
      mode_q <= modeNow;
      taps_q <= tapsNow;
    end
  end

  assign activeMode = mode_q;

  //////////////////////////////////////////////////////////////////////////
  // port mapping: pixel bits onto {C, B, A}

  function [23:0] mapPorts;
    input [2:0]  mode;
    input [1:0]  taps;
    input [23:0] d;
    reg   [7:0]  pa;
    reg   [7:0]  pb;
    reg   [7:0]  pc;
    begin
      pa = 8'h00;
      pb = 8'h00;
      pc = 8'h00;
      case (mode)
        `CLB_MODE_8: begin
          pa = d[7:0];
          if (taps >= 2'h2) begin
            pb = d[15:8];
          end
          if (taps == 2'h3) begin
            pc = d[23:16];
          end
        end
        `CLB_MODE_10: begin
          pa = d[7:0];
          pb = {6'h00, d[9:8]};
          if (taps >= 2'h2) begin
            pc = d[19:12];
            pb = {2'h0, d[21:20], 2'h0, d[9:8]};
          end
        end
        `CLB_MODE_12: begin
          pa = d[7:0];
          pb = {4'h0, d[11:8]};
          if (taps >= 2'h2) begin
            pc = d[19:12];
            pb = {d[23:20], d[11:8]};
          end
        end
        `CLB_MODE_14: begin
          pa = d[7:0];
          pb = {2'h0, d[13:8]};
        end
        `CLB_MODE_16: begin
          pa = d[7:0];
          pb = d[15:8];
        end
        `CLB_MODE_RGB: begin
          pa = d[7:0];
          pb = d[15:8];
          pc = d[23:16];
        end
        default: begin
          pa = 8'h00;
        end
      endcase
      mapPorts = {pc, pb, pa};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // lane slot packing, slot 0 in bit 6

  reg  [7:0] portA;
  reg  [7:0] portB;
  reg  [7:0] portC;
  reg        sDval;
  reg        sFval;
  reg        sLval;
  reg  [6:0] x0;
  reg  [6:0] x1;
  reg  [6:0] x2;
  reg  [6:0] x3;
  reg  [23:0] mapped;

  always @* begin
    mapped = 24'h00_0000;
    sDval  = 1'b0;
    sFval  = 1'b0;
    sLval  = 1'b0;
    if (bufValid) begin
      mapped = mapPorts(modeNow, tapsNow, bufWord[`CLB_DATA_W-1:0]);
      sDval  = bufWord[`CLB_W_DVAL];
      sFval  = bufWord[`CLB_W_FVAL];
      sLval  = bufWord[`CLB_W_LVAL];
    end
    portA = mapped[7:0];
    portB = mapped[15:8];
    portC = mapped[23:16];
    x0 = {portB[0], portA[5], portA[4], portA[3], portA[2], portA[1], portA[0]};
    x1 = {portC[1], portC[0], portB[5], portB[4], portB[3], portB[2], portB[1]};
    x2 = {sDval, sFval, sLval, portC[5], portC[4], portC[3], portC[2]};
    x3 = {1'b0, portC[7], portC[6], portB[7], portB[6], portA[7], portA[6]};
  end

  //////////////////////////////////////////////////////////////////////////
  // serial lanes and forwarded clock

  wire [6:0] laneSlots [0:`CLB_LANES];
  wire [`CLB_LANES:0] serBits;

  assign laneSlots[0] = x0;
  assign laneSlots[1] = x1;
  assign laneSlots[2] = x2;
  assign laneSlots[3] = x3;
  assign laneSlots[4] = `CLB_CLK_PATTERN;

  genvar g;
  generate
    for (g = 0; g <= `CLB_LANES; g = g + 1) begin : gLane
      clb_lane_shifter uSh (
        .mclk   (mclk),
        .nrst   (nrst),
        .load   (wordEdge),
        .slots  (laneSlots[g]),
        .serOut (serBits[g])
      );
    end
  endgenerate

  assign laneOut    = serBits[`CLB_LANES-1:0];
  assign linkClkOut = serBits[`CLB_LANES];

  //////////////////////////////////////////////////////////////////////////
  // underrun: a word slot found the buffer empty, idle word sent

  reg underrun_q;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      underrun_q <= 1'b0;
    end else if (wordEdge) begin
      underrun_q <= ~bufValid;
    end
  end

  assign underrun = underrun_q;

endmodule // clb_serializer

// >>> testbench/clb_link_grabber.sv
// far-side receiver model: frames the lanes back into port words
`timescale 1ns/1ps
module clb_link_grabber (
  // link
  input  wire        mclk,
  input  wire [3:0]  laneOut,
  input  wire        linkClkOut,
  // recovered word {dval, fval, lval, C, B, A}
  output reg         got,
  output reg  [26:0] word
);
  reg  [6:0] x0, x1, x2, x3, ck;
  wire [6:0] n0 = {x0[5:0], laneOut[0]};
  wire [6:0] n1 = {x1[5:0], laneOut[1]};
  wire [6:0] n2 = {x2[5:0], laneOut[2]};
  wire [6:0] n3 = {x3[5:0], laneOut[3]};
  wire [6:0] nc = {ck[5:0], linkClkOut};
  always @(posedge mclk) begin
    x0 <= n0;
    x1 <= n1;
    x2 <= n2;
    x3 <= n3;
    ck <= nc;
    got <= (nc == 7'h63);
    word <= {n2[6:4], n3[5:4], n2[3:0], n1[6:5], n3[3:2], n1[4:0], n0[6], n3[1:0], n0[5:0]};
  end
endmodule // clb_link_grabber

// >>> testbench/clb_serializer_chk.sv
// port assertions for the link serializer
`timescale 1ns/1ps
module clb_serializer_chk (
  // clock and reset
  input wire       mclk,
  input wire       nrst,
  // stream and link
  input wire [2:0] pixMode,
  input wire       pixValid,
  input wire       pixReady,
  input wire       pixFval,
  input wire [3:0] laneOut,
  input wire       linkClkOut,
  input wire [2:0] activeMode,
  input wire       underrun
);
  reg  [3:0] cnt;
  reg  [2:0] hist;
  wire       up = cnt == 4'hf;
  wire       slot0 = up && ({hist, linkClkOut} == 4'h7);
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      hist <= 3'h0;
    end else begin
      cnt <= up ? cnt : cnt + 4'h1;
      hist <= {hist[1:0], linkClkOut};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_clkPeriod; up |-> linkClkOut == $past(linkClkOut, 7); endproperty
  a_clkPeriod: assert property (p_clkPeriod) else $error("link clock not periodic");
  property p_clkShape;
    slot0 |-> ##1 linkClkOut ##1 !linkClkOut [*3] ##1 linkClkOut [*2];
  endproperty
  a_clkShape: assert property (p_clkShape) else $error("link clock shape wrong");
  property p_spare; slot0 |-> !laneOut[3]; endproperty
  a_spare: assert property (p_spare) else $error("spare slot not low");
  property p_rdyBack; up && !pixReady |-> ##[1:7] pixReady; endproperty
  a_rdyBack: assert property (p_rdyBack) else $error("buffer not draining");
  property p_firstRdy; cnt == 4'h1 |-> pixReady; endproperty
  a_firstRdy: assert property (p_firstRdy) else $error("ready late after reset");
  property p_idleZero; slot0 && underrun |-> (laneOut == 4'h0) [*7]; endproperty
  a_idleZero: assert property (p_idleZero) else $error("empty slot not zero");
  property p_urunEdge; up && !$stable(underrun) |-> slot0; endproperty
  a_urunEdge: assert property (p_urunEdge) else $error("underrun moved mid word");
  property p_mode; up && !$stable(activeMode) |-> activeMode == $past(pixMode); endproperty
  a_mode: assert property (p_mode) else $error("mode changed wrongly");
  cover property (up && underrun);
  cover property (pixValid && !pixReady);
  cover property (pixValid && pixReady && pixFval);
endmodule // clb_serializer_chk
bind clb_serializer clb_serializer_chk chk (.mclk(mclk), .nrst(nrst), .pixMode(pixMode),
  .pixValid(pixValid), .pixReady(pixReady), .pixFval(pixFval), .laneOut(laneOut),
  .linkClkOut(linkClkOut), .activeMode(activeMode), .underrun(underrun));

// >>> testbench/tb.sv
// bench for the link serializer: random frames in every pixel mode
`timescale 1ns/1ps
module tb;
  reg         mclk = 1'b0;
  reg         nrst = 1'b0;
  reg  [2:0]  pixMode = 3'h3;
  reg  [1:0]  tapCount = 2'h1;
  reg         pixValid = 1'b0;
  reg  [23:0] pixData = 24'h00_0000;
  reg         pixFval = 1'b0;
  reg         pixLval = 1'b0;
  reg         pixDval = 1'b0;
  reg  [2:0]  md;
  reg  [1:0]  tp;
  reg  [31:0] rnd;
  reg  [26:0] expQ[$];
  wire        pixReady, linkClkOut, underrun, got;
  wire [3:0]  laneOut;
  wire [2:0]  activeMode;
  wire [26:0] word;
  integer     errCount = 0, samplesChecked = 0, cyc = 0, k;
  localparam [32:0] MODES = {3'h2, 3'h1, 3'h3, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0,
                             3'h0};
  localparam [21:0] TAPS  = {2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2,
                             2'h1};
  always #4 mclk = ~mclk;
  clb_serializer DUT (.mclk(mclk), .nrst(nrst), .pixMode(pixMode), .tapCount(tapCount),
    .pixValid(pixValid), .pixReady(pixReady), .pixData(pixData), .pixFval(pixFval),
    .pixLval(pixLval), .pixDval(pixDval), .laneOut(laneOut), .linkClkOut(linkClkOut),
    .activeMode(activeMode), .underrun(underrun));
  clb_link_grabber grab (.mclk(mclk), .laneOut(laneOut), .linkClkOut(linkClkOut),
    .got(got), .word(word));
  task summarize;
    begin
      $display("checks %0d errors %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input [26:0] seen, input [26:0] want);
    begin
      samplesChecked = samplesChecked + 1;
      if (seen !== want) begin
        errCount = errCount + 1;
        $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  // expected {C, B, A} for a mode, tap count and pixel word
  function [23:0] mapPorts(input [2:0] m, input [1:0] t, input [23:0] d);
    case (m)
      3'h0: mapPorts = d & (t == 2'h1 ? 24'h00_00ff : t == 2'h2 ? 24'h00_ffff : 24'hff_ffff);
      3'h1: mapPorts = (t == 2'h1) ? {14'h0000, d[9:0]} :
                       {d[19:12], 2'h0, d[21:20], 2'h0, d[9:0]};
      3'h2: mapPorts = (t == 2'h1) ? {12'h000, d[11:0]} : {d[19:12], d[23:20], d[11:0]};
      3'h3: mapPorts = {10'h000, d[13:0]};
      3'h4: mapPorts = {8'h00, d[15:0]};
      default: mapPorts = d;
    endcase
  endfunction
  task send(input [23:0] d, input f, input l, input v);
    reg r;
    begin
      #1;
      pixValid = 1'b1;
      pixData = d;
      pixFval = f;
      pixLval = l;
      pixDval = v;
      if (f) begin
        pixMode = md;
        tapCount = tp;
      end
      do begin
        @(negedge mclk);
        r = pixReady;
        @(posedge mclk);
      end while (!r);
      expQ.push_back({v, f, l, mapPorts(md, tp, d)});
    end
  endtask
  task frame(input [2:0] m, input [1:0] t);
    integer i;
    begin
      md = m;
      tp = t;
      rnd = $urandom;
      send(rnd[23:0], 1'b1, 1'b0, 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
        rnd = $urandom;
        if (rnd[31:30] == 2'h0) begin
          #1 pixValid = 1'b0;
          repeat (rnd[29:28] + 1) @(posedge mclk);
        end
        send(rnd[23:0], 1'b0, i % 5 != 0, rnd[24]);
      end
      @(negedge mclk);
      check({24'h00_0000, activeMode}, {24'h00_0000, md});
      @(posedge mclk);
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errCount = errCount + 1;
      summarize;
    end
    if (got && expQ.size() > 0 && (word !== 27'h000_0000 || expQ[0] !== 27'h000_0000))
      check(word, expQ.pop_front());
  end
  initial begin
    rnd = $urandom(32'hdf40);
    repeat (6) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge mclk);
    for (k = 0; k < 11; k = k + 1)
      frame(MODES[3*k +: 3], TAPS[2*k +: 2]);
    #1 pixValid = 1'b0;
    repeat (40) @(posedge mclk);
    #2 check(27'(expQ.size()), 27'h000_0000);
    check({26'h000_0000, underrun}, 27'h000_0001);
    summarize;
  end
endmodule // tb
